// >>> rtl/cdd_codec.sv
`timescale 1ns/1ps
`default_nettype none
module cdd_codec #(
    parameter int W = cdd_pkg::CHAR_W
) (
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    input  wire cdd_pkg::cdd_tx_in_t tx_in,
    output logic [W-1:0]             tx_char_q,
    output logic                     tx_char_valid_q,
    output logic                     tx_special_invalid_q,
    input  wire logic                rx_align_en,
    input  wire logic [W-1:0]        rx_word_in,
    output cdd_pkg::cdd_rx_out_t     rx_out_q,
    output logic                     rx_locked
);
    ////////////////////////////////////////////////////////////////////////////
    // sub-block disparity
    function automatic logic rd_six(input logic rd, input logic [5:0] s);
        if ($countones(s) > 3 || s == cdd_pkg::SIX_POS_TIE) begin
            return 1'b1;
        end else if ($countones(s) < 3 || s == cdd_pkg::SIX_NEG_TIE) begin
            return 1'b0;
        end
        return rd;
    endfunction : rd_six

    function automatic logic rd_four(input logic rd, input logic [3:0] f);
        if ($countones(f) > 2 || f == cdd_pkg::FOUR_POS_TIE) begin
            return 1'b1;
        end else if ($countones(f) < 2 || f == cdd_pkg::FOUR_NEG_TIE) begin
            return 1'b0;
        end
        return rd;
    endfunction : rd_four

    function automatic logic char_rd(input logic rd, input logic [W-1:0] c);
        return rd_four(rd_six(rd, c[9:4]), c[3:0]);
    endfunction : char_rd

    ////////////////////////////////////////////////////////////////////////////
    // encoding
    function automatic logic [5:0] enc6(input logic [4:0] x, input logic k, input logic rd);
        logic [5:0] b;
        b = (k && x == cdd_pkg::X_K28) ? cdd_pkg::SIX_K28_NEG : cdd_pkg::ENC6_NEG[x];
        if (rd && ($countones(b) != 3 || b == cdd_pkg::SIX_NEG_TIE)) begin
            return ~b;
        end
        return b;
    endfunction : enc6

    function automatic logic [3:0] enc4(input logic [2:0] y, input logic k,
                                        input logic [4:0] x, input logic rd);
        logic       alt;
        logic [3:0] b;
        alt = (y == 3'h7) && (k || (!rd && cdd_pkg::ALT_NEG_MASK[x]) ||
                              (rd && cdd_pkg::ALT_POS_MASK[x]));
        b = alt ? cdd_pkg::ALT7_NEG : cdd_pkg::ENC4_NEG[y];
        if (k) begin
            return (rd ^ ($countones(b) == 2 && b != cdd_pkg::FOUR_NEG_TIE)) ? ~b : b;
        end else if (rd && ($countones(b) != 2 || b == cdd_pkg::FOUR_NEG_TIE)) begin
            return ~b;
        end
        return b;
    endfunction : enc4

    function automatic logic [W-1:0] encode(input logic [7:0] byte_in, input logic k,
                                            input logic rd);
        logic [5:0] six;
        six = enc6(byte_in[4:0], k, rd);
        return {six, enc4(byte_in[7:5], k, byte_in[4:0], rd_six(rd, six))};
    endfunction : encode

    function automatic logic k_legal(input logic [7:0] b);
        return b[4:0] == cdd_pkg::X_K28 || (b[7:5] == 3'h7 && cdd_pkg::K_SEVEN_MASK[b[4:0]]);
    endfunction : k_legal

    ////////////////////////////////////////////////////////////////////////////
    // transmit
    logic       tx_rd_q;
    logic       tx_rd_use;
    logic [7:0] tx_byte;
    logic       tx_k;
    logic       tx_bad;
    logic [W-1:0] tx_code;

    always_comb begin
        tx_rd_use = tx_rd_q;
        tx_byte   = tx_in.data;
        tx_k      = tx_in.special_char_select;
        tx_bad    = 1'b0;
        if (tx_k) begin
            if (tx_in.data == cdd_pkg::CODE_C1_7) begin
                tx_byte   = cdd_pkg::BYTE_K28_5;
                tx_rd_use = 1'b0;
            end else if (tx_in.data == cdd_pkg::CODE_C2_7) begin
                tx_byte   = cdd_pkg::BYTE_K28_5;
                tx_rd_use = 1'b1;
            end else if (!k_legal(tx_in.data)) begin
                tx_byte   = cdd_pkg::BYTE_K28_5;
                tx_bad    = 1'b1;
            end
        end
        tx_code = encode(tx_byte, tx_k, tx_rd_use);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_rd_q              <= cdd_pkg::RD_RESET;
            tx_char_q            <= '0;
            tx_char_valid_q      <= 1'b0;
            tx_special_invalid_q <= 1'b0;
        end else if (clk_en) begin
            tx_char_valid_q      <= tx_in.valid;
            tx_special_invalid_q <= tx_in.valid & tx_bad;
            if (tx_in.valid) begin
                tx_char_q <= tx_code;
                tx_rd_q   <= char_rd(tx_rd_use, tx_code);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive alignment
    logic [W-1:0] rx_char;
    logic         rx_char_v;

    cdd_align #(
        .W (W)
    ) u_align (
        .sys_clk      (sys_clk),
        .reset_n      (reset_n),
        .clk_en       (clk_en),
        .align_en     (rx_align_en),
        .word_in      (rx_word_in),
        .char_q       (rx_char),
        .char_valid_q (rx_char_v),
        .locked_q     (rx_locked)
    );

    ////////////////////////////////////////////////////////////////////////////
    // receive decode and check
    logic         rx_rd_q;
    logic         rx_rd_prev_q;
    logic [W-1:0] rx_char_q;
    logic [4:0]   dx;
    logic [2:0]   dy;
    logic         dk;
    logic         hit;

    always_comb begin
        dx  = '0;
        dy  = '0;
        dk  = 1'b0;
        hit = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (enc6(5'(i), 1'b0, 1'b0) == rx_char[9:4] ||
                enc6(5'(i), 1'b0, 1'b1) == rx_char[9:4]) begin
                dx = 5'(i);
            end
        end
        if (rx_char[9:4] == cdd_pkg::SIX_K28_NEG || rx_char[9:4] == ~cdd_pkg::SIX_K28_NEG) begin
            dx = cdd_pkg::X_K28;
        end
        for (int j = 0; j < 8; j++) begin
            for (int kk = 0; kk < 2; kk++) begin
                if ((kk == 0 || k_legal({3'(j), dx})) &&
                    encode({3'(j), dx}, 1'(kk), rx_rd_q) == rx_char) begin
                    hit = 1'b1;
                    dy  = 3'(j);
                    dk  = 1'(kk);
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_rd_q      <= cdd_pkg::RD_RESET;
            rx_rd_prev_q <= cdd_pkg::RD_RESET;
            rx_char_q    <= '0;
            rx_out_q     <= '0;
        end else if (clk_en) begin
            rx_out_q.valid <= rx_char_v;
            if (rx_char_v) begin
                rx_rd_q            <= char_rd(rx_rd_q, rx_char);
                rx_rd_prev_q       <= rx_rd_q;
                rx_char_q          <= rx_char;
                rx_out_q.special   <= dk;
                rx_out_q.violation <= ~hit;
                rx_out_q.data      <= {dy, dx};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_tx_char_out: assert property ((clk_en && tx_in.valid) |=> tx_char_valid_q)
        else $error("no character after a valid byte");
    chk_tx_balance: assert property (tx_char_valid_q |-> ($countones(tx_char_q) inside {4, 5, 6}))
        else $error("transmitted character out of balance");
    chk_tx_rd_track: assert property ((clk_en && tx_in.valid) |=>
        tx_rd_q == rd_four(rd_six($past(tx_rd_use), tx_char_q[9:4]), tx_char_q[3:0]))
        else $error("transmit disparity not taken from sent character");
    chk_force_neg: assert property ((clk_en && tx_in.valid && tx_in.special_char_select &&
        tx_in.data == cdd_pkg::CODE_C1_7) |=> (tx_char_q == 10'h0fa && tx_rd_q == 1'b1))
        else $error("forced negative comma not sent");
    chk_force_pos: assert property ((clk_en && tx_in.valid && tx_in.special_char_select &&
        tx_in.data == cdd_pkg::CODE_C2_7) |=> (tx_char_q == 10'h305 && tx_rd_q == 1'b0))
        else $error("forced positive comma not sent");
    chk_tx_data_map: assert property ((clk_en && tx_in.valid && !tx_in.special_char_select)
        |=> (tx_char_q[9:4] == enc6($past(tx_in.data[4:0]), 1'b0, $past(tx_rd_q))))
        else $error("data character six-bit block mismatch");
    chk_rx_roundtrip: assert property ((rx_out_q.valid && !rx_out_q.violation) |->
        encode(rx_out_q.data, rx_out_q.special, rx_rd_prev_q) == rx_char_q)
        else $error("accepted character does not re-encode");
    chk_rx_rd_track: assert property ((clk_en && rx_char_v) |=>
        rx_rd_q == rd_four(rd_six($past(rx_rd_q), rx_char_q[9:4]), rx_char_q[3:0]))
        else $error("receive disparity not updated");
    chk_rx_unbal_bad: assert property ((rx_out_q.valid &&
        !($countones(rx_char_q) inside {4, 5, 6})) |-> rx_out_q.violation)
        else $error("unbalanced character accepted");
endmodule : cdd_codec
`default_nettype wire

// >>> rtl/cdd_pkg.sv
package cdd_pkg;
    localparam int          CHAR_W        = 10;
    localparam int          BYTE_W        = 8;
    localparam logic        RD_RESET      = 1'h0;
    localparam logic [7:0]  CODE_C1_7     = 8'he1;
    localparam logic [7:0]  CODE_C2_7     = 8'he2;
    localparam logic [7:0]  BYTE_K28_5    = 8'hbc;
    localparam logic [4:0]  X_K28         = 5'h1c;
    localparam logic [5:0]  SIX_K28_NEG   = 6'h0f;
    localparam logic [5:0]  SIX_POS_TIE   = 6'h07;
    localparam logic [5:0]  SIX_NEG_TIE   = 6'h38;
    localparam logic [3:0]  FOUR_POS_TIE  = 4'h3;
    localparam logic [3:0]  FOUR_NEG_TIE  = 4'hc;
    localparam logic [3:0]  ALT7_NEG      = 4'h7;
    localparam logic [31:0] ALT_NEG_MASK  = 32'h00160000;
    localparam logic [31:0] ALT_POS_MASK  = 32'h00006800;
    localparam logic [31:0] K_SEVEN_MASK  = 32'h68800000;
    localparam logic [6:0]  COMMA_NEG     = 7'h1f;
    localparam logic [6:0]  COMMA_POS     = 7'h60;
    localparam logic [3:0]  OFFSET_RESET  = 4'h0;

    // abcdei for the negative column, a in the msb
    localparam logic [5:0] ENC6_NEG [0:31] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b
    };
    // fghj for the negative column, f in the msb
    localparam logic [3:0] ENC4_NEG [0:7] = '{
        4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he
    };

    typedef struct packed {
        logic             valid;
        logic             special_char_select;
        logic [BYTE_W-1:0] data;
    } cdd_tx_in_t;

    typedef struct packed {
        logic             valid;
        logic             special;
        logic             violation;
        logic [BYTE_W-1:0] data;
    } cdd_rx_out_t;
endpackage : cdd_pkg

// >>> rtl/cdd_align.sv
`timescale 1ns/1ps
`default_nettype none
module cdd_align #(
    parameter int W = 10
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    input  wire logic         align_en,
    input  wire logic [W-1:0] word_in,
    output logic      [W-1:0] char_q,
    output logic              char_valid_q,
    output logic              locked_q
);
    logic [W-1:0]   sync1_q;
    logic [W-1:0]   sync2_q;
    logic [W-1:0]   prev_q;
    logic [3:0]     off_q;
    logic [2*W-1:0] win;
    logic           found;
    logic [3:0]     found_off;
    logic [3:0]     off_use;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else if (clk_en) begin
            sync1_q <= word_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // comma search over every bit offset of the two-word window
    always_comb begin
        win       = {prev_q, sync2_q};
        found     = 1'b0;
        found_off = cdd_pkg::OFFSET_RESET;
        for (int o = W - 1; o >= 0; o--) begin
            if (win[2*W-1-o -: 7] == cdd_pkg::COMMA_NEG ||
                win[2*W-1-o -: 7] == cdd_pkg::COMMA_POS) begin
                found     = 1'b1;
                found_off = 4'(o);
            end
        end
        off_use = (found && align_en) ? found_off : off_q;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            off_q        <= cdd_pkg::OFFSET_RESET;
            locked_q     <= 1'b0;
            char_q       <= '0;
            char_valid_q <= 1'b0;
        end else if (clk_en) begin
            if (found && align_en) begin
                off_q    <= found_off;
                locked_q <= 1'b1;
            end
            char_q       <= win[2*W-1-int'(off_use) -: W];
            char_valid_q <= locked_q | (found & align_en);
        end
    end

    chk_comma_framed: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (clk_en && found && align_en) |=>
        (char_q[W-1 -: 7] == cdd_pkg::COMMA_NEG || char_q[W-1 -: 7] == cdd_pkg::COMMA_POS))
        else $error("comma not at character start after alignment");
endmodule : cdd_align
`default_nettype wire

// >>> test/cdd_serdes_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdd_serdes_model (
    input  wire logic       sys_clk,
    input  wire logic [9:0] tx_char,
    input  wire logic [3:0] bit_offset,
    output logic      [9:0] rx_word
);
    logic [9:0]  prev_q;
    logic [19:0] win;

    ////////////////////////////////////////////////////////////////////////////
    // line sends bit a first; each character starts bit_offset bits after the word boundary
    always_ff @(posedge sys_clk) begin
        prev_q <= tx_char;
    end

    assign win     = {prev_q, tx_char} >> bit_offset;
    assign rx_word = win[9:0];
endmodule : cdd_serdes_model
`default_nettype wire

// >>> test/code_8b10b_disparity_bench.sv
`timescale 1ns/1ps
`default_nettype none
module code_8b10b_disparity_bench;
    logic                 sys_clk;
    logic                 reset_n;
    logic                 clk_en;
    logic                 rx_align_en;
    cdd_pkg::cdd_tx_in_t  tx_in;
    cdd_pkg::cdd_rx_out_t rx_out;
    cdd_pkg::cdd_rx_out_t rxq [$];
    logic [9:0]           tx_char;
    logic [9:0]           rx_word;
    logic [3:0]           bit_offset;
    logic                 tx_char_valid;
    logic                 tx_inv;
    logic                 rx_locked;
    int                   bad_count;
    int                   compares;
    int                   cycles;

    cdd_codec u_cdd_codec (
        .sys_clk              (sys_clk),
        .reset_n              (reset_n),
        .clk_en               (clk_en),
        .tx_in                (tx_in),
        .tx_char_q            (tx_char),
        .tx_char_valid_q      (tx_char_valid),
        .tx_special_invalid_q (tx_inv),
        .rx_align_en          (rx_align_en),
        .rx_word_in           (rx_word),
        .rx_out_q             (rx_out),
        .rx_locked            (rx_locked)
    );

    cdd_serdes_model u_cdd_serdes_model (
        .sys_clk    (sys_clk),
        .tx_char    (tx_char),
        .bit_offset (bit_offset),
        .rx_word    (rx_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    always #20 sys_clk = ~sys_clk;

    always @(negedge sys_clk) begin
        if (rx_out.valid === 1'b1) begin
            rxq.push_back(rx_out);
        end
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input string what, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic do_reset;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        tx_in   <= '0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
    endtask : do_reset

    // tie cases, forced columns, illegal special, back to back
    task automatic tx_sequence;
        logic [8:0] stim [0:8] = '{9'h007, 9'h007, 9'h003, 9'h000, 9'h1e2,
                                   9'h1e1, 9'h045, 9'h100, 9'h1bc};
        logic [9:0] exp  [0:8] = '{10'h38b, 10'h074, 10'h31b, 10'h18b, 10'h305,
                                   10'h0fa, 10'h295, 10'h305, 10'h0fa};
        for (int i = 0; i <= 9; i++) begin
            @(posedge sys_clk);
            tx_in <= (i < 9) ? {1'b1, stim[i]} : '0;
            @(negedge sys_clk);
            if (i > 0) begin
                check_val("tx char", exp[i-1], tx_char);
                check_val("tx valid", 10'h1, {9'h0, tx_char_valid});
                check_val("tx invalid", {9'h0, i == 8}, {9'h0, tx_inv});
            end
        end
        @(negedge sys_clk);
        check_val("tx valid end", 10'h0, {9'h0, tx_char_valid});
    endtask : tx_sequence

    // clock enable low freezes the transmitter with a byte waiting
    task automatic hold_sequence;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        tx_in  <= {1'b1, 9'h000};
        repeat (3) @(negedge sys_clk);
        check_val("held char", 10'h0fa, tx_char);
        check_val("held valid", 10'h0, {9'h0, tx_char_valid});
        @(posedge sys_clk);
        clk_en <= 1'b1;
        @(posedge sys_clk);
        tx_in <= '0;
        @(negedge sys_clk);
        check_val("char after hold", 10'h18b, tx_char);
        check_val("valid after hold", 10'h1, {9'h0, tx_char_valid});
    endtask : hold_sequence

    // comma lock at an offset, violation, decode after it
    task automatic rx_sequence(input logic [3:0] off);
        logic [8:0] stim [0:10] = '{9'h1bc, 9'h1bc, 9'h1bc, 9'h1bc, 9'h1e1, 9'h1e1,
                                    9'h007, 9'h1bc, 9'h1bc, 9'h1bc, 9'h1bc};
        int k;
        bit_offset <= off;
        do_reset();
        check_val("locked idle", 10'h0, {9'h0, rx_locked});
        rxq.delete();
        for (int i = 0; i < 11; i++) begin
            @(posedge sys_clk);
            tx_in <= {1'b1, stim[i]};
        end
        @(posedge sys_clk);
        tx_in <= '0;
        repeat (8) @(negedge sys_clk);
        check_val("locked", 10'h1, {9'h0, rx_locked});
        k = -1;
        foreach (rxq[j]) begin
            if (k < 0 && rxq[j].violation === 1'b1) begin
                k = j;
            end
        end
        if (k < 1 || k + 1 >= rxq.size()) begin
            check_val("violation seen", 10'h1, 10'h0);
        end else begin
            check_val("rx before", 10'h2bc, {rxq[k-1].special, rxq[k-1].violation,
                      rxq[k-1].data});
            check_val("rx after", 10'h007, {rxq[k+1].special, rxq[k+1].violation,
                      rxq[k+1].data});
        end
    endtask : rx_sequence

    task automatic finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk     = 1'b0;
        reset_n     = 1'b0;
        clk_en      = 1'b1;
        rx_align_en = 1'b1;
        tx_in       = '0;
        bit_offset  = 4'h0;
        bad_count   = 0;
        compares    = 0;
        cycles      = 0;
        do_reset();
        tx_sequence();
        hold_sequence();
        rx_sequence(4'h3);
        rx_sequence(4'h7);
        rx_sequence(4'h0);
        finish_test();
    end
endmodule : code_8b10b_disparity_bench
`default_nettype wire
